//--- hdl/fps_flash_array.sv
`timescale 1ns/1ps
module fps_flash_array #(
   parameter int ADDR_W = 16
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic wr_erase,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [7:0] rd_data
);

   logic [7:0] mem [0:(1<<ADDR_W)-1];

   // Programming only clears bits; erase is the only path back to ones
   always_ff @(posedge clk) begin
      if (wr_en) begin
         if (wr_erase) begin
            mem[wr_addr] <= fps_pkg::ERASED_BYTE;
         end else begin
            mem[wr_addr] <= mem[wr_addr] & wr_data;
         end
      end
   end

   // Registered read for code and constant fetch
   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end

endmodule

//--- hdl/fps_flash_sequencer.sv
// Overview of operation
// - Programming only clears bits to zero
// - Erase sets a whole 512-byte page to 0xFF
// - Write and erase timed internally to completion
// - Processor stalled while an operation runs
// - Keys 0xA5 then 0xF1 before each operation
// - Wrong key or order disables until reset
// - Operation before keys disables until reset
// - Lock re-arms after every write or erase
// - Write enable steers moves to flash, sticky
// - Erase and write enable: move erases page
// - Write enable only: move programs one byte
// - Short-address moves cannot reach above 0x00FF
// - Block write caches first byte, commits pair
// - Lone cached byte is never committed
// - Debug port also programs and erases flash
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module fps_flash_sequencer #(
   parameter int ADDR_W = 16,
   parameter int WRITE_CYCLES = fps_pkg::WRITE_CYCLES,
   parameter int ERASE_CYCLES = fps_pkg::ERASE_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic [7:0] PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic XMOVE_WR,
   input wire logic XMOVE_SHORT,
   input wire logic [15:0] XMOVE_ADDR,
   input wire logic [7:0] XMOVE_DATA,
   output logic XRAM_WR,
   output logic [15:0] XRAM_ADDR,
   output logic [7:0] XRAM_DATA,
   input wire logic DBG_REQ,
   input wire logic DBG_ERASE,
   input wire logic [ADDR_W-1:0] DBG_ADDR,
   input wire logic [7:0] DBG_DATA,
   output logic DBG_DONE,
   input wire logic [ADDR_W-1:0] CODE_ADDR,
   output logic [7:0] CODE_DATA,
   output logic CPU_STALL
);

   logic write_enable;
   logic erase_enable;
   logic timing_enable;
   logic block_write;
   fps_pkg::fps_key_state_t key_state;
   fps_pkg::fps_seq_state_t seq_state;
   logic [fps_pkg::COUNT_W-1:0] count;
   logic [ADDR_W-1:0] op_addr;
   logic [7:0] op_data0;
   logic [7:0] op_data1;
   logic op_pair;
   logic op_from_dbg;
   logic cache_valid;
   logic [ADDR_W-1:0] cache_addr;
   logic [7:0] cache_data;
   logic apb_access;
   logic apb_wr;
   logic key_wr;
   logic [15:0] move_addr;
   logic [ADDR_W-1:0] flash_addr;
   logic flash_move;
   logic attempt;
   logic launch_ok;
   logic start_erase;
   logic start_prog;
   logic start_pair;
   logic cache_fill;
   logic dbg_start;
   logic op_last;
   logic mem_we;
   logic mem_erase;
   logic [ADDR_W-1:0] mem_addr;
   logic [7:0] mem_data;
   logic [31:0] next_rdata;
   logic next_slverr;

   localparam logic [fps_pkg::COUNT_W-1:0] WRITE_LAST = fps_pkg::COUNT_W'(WRITE_CYCLES - 1);
   localparam logic [fps_pkg::COUNT_W-1:0] ERASE_LAST = fps_pkg::COUNT_W'(ERASE_CYCLES - 1);
   localparam logic [fps_pkg::COUNT_W-1:0] PAGE_LAST =
      fps_pkg::COUNT_W'(fps_pkg::PAGE_BYTES - 1);

   // APB access phase; one wait state so PREADY can come from a flop
   assign apb_access = PSEL && PENABLE && !PREADY;
   assign apb_wr = apb_access && PWRITE;
   assign key_wr = apb_wr && (PADDR == fps_pkg::UNLOCK_KEY_OFS);

   // Short-form moves carry only a low address byte
   assign move_addr = XMOVE_SHORT ? (XMOVE_ADDR & fps_pkg::SHORT_MOVE_LIMIT) :
                                    XMOVE_ADDR;
   assign flash_addr = move_addr[ADDR_W-1:0];

   // A move is a flash access while write enable is set
   assign flash_move = XMOVE_WR && write_enable;
   assign attempt = flash_move && (key_state != fps_pkg::FPS_KEY_DEAD);
   assign launch_ok = attempt && (key_state == fps_pkg::FPS_KEY_OPEN) && timing_enable &&
                      (seq_state == fps_pkg::FPS_SEQ_IDLE);

   // Operation selection from the enables and block mode
   assign start_erase = launch_ok && erase_enable;
   assign start_prog = launch_ok && !erase_enable && !block_write;
   assign start_pair = launch_ok && !erase_enable && block_write && cache_valid &&
                       (flash_addr == cache_addr + ADDR_W'(1));
   assign cache_fill = launch_ok && !erase_enable && block_write && !start_pair;
   // Done blocks a restart: the port can only drop its request once it has seen done
   assign dbg_start = DBG_REQ && (seq_state == fps_pkg::FPS_SEQ_IDLE) && !launch_ok &&
                      !DBG_DONE;

   // Unlock sequence checker
   fps_key_lock u_key_lock (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .key_wr(key_wr),
      .key_data(PWDATA[7:0]),
      .attempt(attempt),
      .state(key_state)
   );

   // Program store control; bits stay until software writes them
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         write_enable <= fps_pkg::PROG_STORE_CTRL_RST[fps_pkg::WRITE_ENABLE_BIT];
         erase_enable <= fps_pkg::PROG_STORE_CTRL_RST[fps_pkg::ERASE_ENABLE_BIT];
      end else if (apb_wr && (PADDR == fps_pkg::PROG_STORE_CTRL_OFS)) begin
         write_enable <= PWDATA[fps_pkg::WRITE_ENABLE_BIT];
         erase_enable <= PWDATA[fps_pkg::ERASE_ENABLE_BIT];
      end
   end

   // Scale and cache control bits
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         timing_enable <= fps_pkg::TIMING_ENABLE_RST;
         block_write <= fps_pkg::BLOCK_WRITE_RST;
      end else if (apb_wr) begin
         if (PADDR == fps_pkg::FLASH_SCALE_OFS) begin
            timing_enable <= PWDATA[fps_pkg::TIMING_ENABLE_BIT];
         end
         if (PADDR == fps_pkg::CACHE_CTRL_OFS) begin
            block_write <= PWDATA[fps_pkg::BLOCK_WRITE_BIT];
         end
      end
   end

   // Block-write cache; dropping block mode discards a lone byte
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         cache_valid <= 1'b0;
         cache_addr <= '0;
         cache_data <= 8'h00;
      end else if (!block_write || start_pair || start_erase) begin
         cache_valid <= 1'b0;
      end else if (cache_fill) begin
         cache_valid <= 1'b1;
         cache_addr <= flash_addr;
         cache_data <= XMOVE_DATA;
      end
   end

   // Operation latch; a pair commits cached byte then new byte
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         op_addr <= '0;
         op_data0 <= 8'h00;
         op_data1 <= 8'h00;
         op_pair <= 1'b0;
         op_from_dbg <= 1'b0;
      end else if (start_pair) begin
         op_addr <= cache_addr;
         op_data0 <= cache_data;
         op_data1 <= XMOVE_DATA;
         op_pair <= 1'b1;
         op_from_dbg <= 1'b0;
      end else if (start_prog || start_erase) begin
         op_addr <= flash_addr;
         op_data0 <= XMOVE_DATA;
         op_pair <= 1'b0;
         op_from_dbg <= 1'b0;
      end else if (dbg_start) begin
         op_addr <= DBG_ADDR;
         op_data0 <= DBG_DATA;
         op_pair <= 1'b0;
         op_from_dbg <= 1'b1;
      end
   end

   // Timed operation; a pair fits inside one byte time
   assign op_last = (seq_state == fps_pkg::FPS_SEQ_PROG) ? (count == WRITE_LAST) :
                    (count == ERASE_LAST);

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         seq_state <= fps_pkg::FPS_SEQ_IDLE;
         count <= '0;
      end else begin
         case (seq_state)
            fps_pkg::FPS_SEQ_IDLE: begin
               count <= '0;
               if (start_erase || (dbg_start && DBG_ERASE)) begin
                  seq_state <= fps_pkg::FPS_SEQ_ERASE;
               end else if (start_prog || start_pair || dbg_start) begin
                  seq_state <= fps_pkg::FPS_SEQ_PROG;
               end
            end
            fps_pkg::FPS_SEQ_PROG, fps_pkg::FPS_SEQ_ERASE: begin
               if (op_last) begin
                  seq_state <= fps_pkg::FPS_SEQ_IDLE;
                  count <= '0;
               end else begin
                  count <= count + fps_pkg::COUNT_W'(1);
               end
            end
            default: begin
               seq_state <= fps_pkg::FPS_SEQ_IDLE;
            end
         endcase
      end
   end

   // Array write port driven by the running operation
   always_comb begin
      mem_we = 1'b0;
      mem_erase = 1'b0;
      mem_addr = op_addr;
      mem_data = op_data0;
      if (seq_state == fps_pkg::FPS_SEQ_ERASE && count <= PAGE_LAST) begin
         mem_we = 1'b1;
         mem_erase = 1'b1;
         mem_addr = {op_addr[ADDR_W-1:fps_pkg::PAGE_BITS],
                     count[fps_pkg::PAGE_BITS-1:0]};
      end else if (seq_state == fps_pkg::FPS_SEQ_PROG) begin
         if (count == '0) begin
            mem_we = 1'b1;
         end else if (count == fps_pkg::COUNT_W'(1) && op_pair) begin
            mem_we = 1'b1;
            mem_addr = op_addr + ADDR_W'(1);
            mem_data = op_data1;
         end
      end
   end

   fps_flash_array #(
      .ADDR_W(ADDR_W)
   ) u_array (
      .clk(REF_CLK),
      .wr_en(mem_we),
      .wr_erase(mem_erase),
      .wr_addr(mem_addr),
      .wr_data(mem_data),
      .rd_addr(CODE_ADDR),
      .rd_data(CODE_DATA)
   );

   // Stall from the launch edge through the last timed cycle
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         CPU_STALL <= 1'b0;
      end else if (start_erase || start_prog || start_pair || dbg_start) begin
         CPU_STALL <= 1'b1;
      end else if (seq_state != fps_pkg::FPS_SEQ_IDLE && op_last) begin
         CPU_STALL <= 1'b0;
      end
   end

   // Debug completion pulse
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         DBG_DONE <= 1'b0;
      end else begin
         DBG_DONE <= (seq_state != fps_pkg::FPS_SEQ_IDLE) && op_last && op_from_dbg;
      end
   end

   // Moves not aimed at flash go on to data memory
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         XRAM_WR <= 1'b0;
         XRAM_ADDR <= 16'h0000;
         XRAM_DATA <= 8'h00;
      end else begin
         XRAM_WR <= XMOVE_WR && !write_enable;
         if (XMOVE_WR && !write_enable) begin
            XRAM_ADDR <= move_addr;
            XRAM_DATA <= XMOVE_DATA;
         end
      end
   end

   // Read mux; unmapped addresses answer zero with an error
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_slverr = 1'b0;
      case (PADDR)
         fps_pkg::PROG_STORE_CTRL_OFS: begin
            next_rdata[fps_pkg::WRITE_ENABLE_BIT] = write_enable;
            next_rdata[fps_pkg::ERASE_ENABLE_BIT] = erase_enable;
         end
         fps_pkg::UNLOCK_KEY_OFS: begin
            next_rdata[1:0] = key_state;
         end
         fps_pkg::FLASH_SCALE_OFS: begin
            next_rdata[fps_pkg::TIMING_ENABLE_BIT] = timing_enable;
         end
         fps_pkg::CACHE_CTRL_OFS: begin
            next_rdata[fps_pkg::BLOCK_WRITE_BIT] = block_write;
         end
         fps_pkg::SEQ_STATUS_OFS: begin
            next_rdata[fps_pkg::STAT_BUSY_BIT] = (seq_state != fps_pkg::FPS_SEQ_IDLE);
            next_rdata[fps_pkg::STAT_DISABLED_BIT] = (key_state == fps_pkg::FPS_KEY_DEAD);
            next_rdata[fps_pkg::STAT_CACHED_BIT] = cache_valid;
         end
         default: begin
            next_slverr = 1'b1;
         end
      endcase
   end

   // APB answer registers
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= apb_access;
         PSLVERR <= apb_access && next_slverr;
         if (apb_access && !PWRITE) begin
            PRDATA <= next_rdata;
         end
      end
   end

endmodule

//--- hdl/fps_key_lock.sv
`timescale 1ns/1ps
module fps_key_lock (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic key_wr,
   input wire logic [7:0] key_data,
   input wire logic attempt,
   output fps_pkg::fps_key_state_t state
);

   // Dead state is left only by system reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= fps_pkg::FPS_KEY_LOCKED;
      end else begin
         case (state)
            fps_pkg::FPS_KEY_LOCKED: begin
               if (attempt) begin
                  state <= fps_pkg::FPS_KEY_DEAD;
               end else if (key_wr) begin
                  state <= (key_data == fps_pkg::FIRST_KEY) ? fps_pkg::FPS_KEY_HALF :
                                                             fps_pkg::FPS_KEY_DEAD;
               end
            end
            fps_pkg::FPS_KEY_HALF: begin
               if (attempt) begin
                  state <= fps_pkg::FPS_KEY_DEAD;
               end else if (key_wr) begin
                  state <= (key_data == fps_pkg::SECOND_KEY) ? fps_pkg::FPS_KEY_OPEN :
                                                              fps_pkg::FPS_KEY_DEAD;
               end
            end
            fps_pkg::FPS_KEY_OPEN: begin
               if (attempt) begin
                  state <= fps_pkg::FPS_KEY_LOCKED;
               end else if (key_wr) begin
                  state <= fps_pkg::FPS_KEY_DEAD;
               end
            end
            default: begin
               state <= fps_pkg::FPS_KEY_DEAD;
            end
         endcase
      end
   end

endmodule

//--- hdl/fps_pkg.sv
package fps_pkg;

   // Register byte offsets on the APB slave
   localparam logic [7:0] PROG_STORE_CTRL_OFS = 8'h00;
   localparam logic [7:0] UNLOCK_KEY_OFS = 8'h04;
   localparam logic [7:0] FLASH_SCALE_OFS = 8'h08;
   localparam logic [7:0] CACHE_CTRL_OFS = 8'h0c;
   localparam logic [7:0] SEQ_STATUS_OFS = 8'h10;

   // Field positions
   localparam int WRITE_ENABLE_BIT = 0;
   localparam int ERASE_ENABLE_BIT = 1;
   localparam int TIMING_ENABLE_BIT = 0;
   localparam int BLOCK_WRITE_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DISABLED_BIT = 1;
   localparam int STAT_CACHED_BIT = 2;

   // Reset values
   localparam logic [1:0] PROG_STORE_CTRL_RST = 2'h0;
   localparam logic TIMING_ENABLE_RST = 1'b0;
   localparam logic BLOCK_WRITE_RST = 1'b0;

   // Key codes and flash values
   localparam logic [7:0] FIRST_KEY = 8'ha5;
   localparam logic [7:0] SECOND_KEY = 8'hf1;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [15:0] SHORT_MOVE_LIMIT = 16'h00ff;

   // Page geometry and timing counts
   localparam int PAGE_BYTES = 512;
   localparam int PAGE_BITS = 9;
   localparam int WRITE_CYCLES = 16;
   localparam int ERASE_CYCLES = 1024;
   localparam int COUNT_W = 16;

   // Unlock sequence states
   typedef enum logic [1:0] {
      FPS_KEY_LOCKED = 2'b00,
      FPS_KEY_HALF = 2'b01,
      FPS_KEY_OPEN = 2'b10,
      FPS_KEY_DEAD = 2'b11
   } fps_key_state_t;

   // Sequencer states
   typedef enum logic [1:0] {
      FPS_SEQ_IDLE = 2'b00,
      FPS_SEQ_PROG = 2'b01,
      FPS_SEQ_ERASE = 2'b10
   } fps_seq_state_t;

endpackage

//--- testbench/fps_core_model.sv
`timescale 1ns/1ps
module fps_core_model (
   input wire logic clk,
   input wire logic stall,
   output logic move_wr,
   output logic move_short,
   output logic [15:0] move_addr,
   output logic [7:0] move_data
);
   initial begin
      move_wr = 1'h0;
      move_short = 1'h0;
      move_addr = 16'h0;
      move_data = 8'h0;
   end
   // One store, then sit out the stall; idle address and data show the inverse
   task automatic store(input logic s, input logic [15:0] a, input logic [7:0] d,
                        output int n);
      @(posedge clk);
      move_wr <= 1'h1;
      move_short <= s;
      move_addr <= a;
      move_data <= d;
      @(posedge clk);
      move_wr <= 1'h0;
      move_addr <= ~a;
      move_data <= ~d;
      n = 0;
      #1;
      while (stall && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
endmodule

//--- testbench/fps_seq_properties.sv
`timescale 1ns/1ps
module fps_seq_properties #(
   parameter int WRITE_CYCLES = 16,
   parameter int ERASE_CYCLES = 1024
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic XMOVE_WR,
   input wire logic [7:0] XMOVE_DATA,
   input wire logic XRAM_WR,
   input wire logic [7:0] XRAM_DATA,
   input wire logic DBG_REQ,
   input wire logic DBG_DONE,
   input wire logic CPU_STALL
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);
   logic [15:0] run;
   // Length of the current stall, so that its end can be judged
   always_ff @(posedge REF_CLK) begin
      if (!RST_N || !CPU_STALL) begin
         run <= 16'h0;
      end else begin
         run <= run + 16'h1;
      end
   end
   property p_ready;
      PSEL && PENABLE && !PREADY |=> PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("apb answer late");
   property p_err;
      PSLVERR |-> PREADY && $past(PSEL) && $past(PENABLE);
   endproperty
   a_err: assert property (p_err) else $error("error without access");
   property p_stall_len;
      $fell(CPU_STALL) |-> run == WRITE_CYCLES || run == ERASE_CYCLES;
   endproperty
   a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
   // Stall length is bounded by the counter; a delay range this long would slow the tools
   property p_stall_end;
      CPU_STALL |-> run < ERASE_CYCLES;
   endproperty
   a_stall_end: assert property (p_stall_end) else $error("stall never ends");
   property p_stall_cause;
      $rose(CPU_STALL) |-> $past(XMOVE_WR) || $past(DBG_REQ);
   endproperty
   a_stall_cause: assert property (p_stall_cause) else $error("stall from nothing");
   property p_xram;
      XRAM_WR |-> $past(XMOVE_WR) && XRAM_DATA == $past(XMOVE_DATA);
   endproperty
   a_xram: assert property (p_xram) else $error("ram store mismatch");
   property p_xram_quiet;
      XRAM_WR |-> !$rose(CPU_STALL);
   endproperty
   a_xram_quiet: assert property (p_xram_quiet) else $error("ram store stalled");
   property p_dbg;
      DBG_DONE |-> $fell(CPU_STALL) && $past(DBG_REQ);
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug done misplaced");
   property p_dbg_pulse;
      DBG_DONE |=> !DBG_DONE;
   endproperty
   a_dbg_pulse: assert property (p_dbg_pulse) else $error("debug done too long");
   c_erase: cover property (CPU_STALL [*8]);
   c_xram: cover property (XRAM_WR);
   c_dbg: cover property (DBG_DONE);
endmodule
bind fps_flash_sequencer fps_seq_properties #(
   .WRITE_CYCLES(WRITE_CYCLES),
   .ERASE_CYCLES(ERASE_CYCLES)
) chk_u (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PREADY, .PSLVERR, .XMOVE_WR, .XMOVE_DATA,
   .XRAM_WR, .XRAM_DATA, .DBG_REQ, .DBG_DONE, .CPU_STALL);

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int WR_N = 4;
   localparam int ER_N = 512;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, xwr, xshort, xram_wr;
   logic dbg_req, dbg_erase, dbg_done, stall, er;
   logic [7:0] paddr, xdata, xram_data, dbg_data, code_data, ram_d;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] xaddr, xram_addr, dbg_addr, code_addr, ram_a;
   int miscompares = 0, samples_checked = 0, cycles = 0, ram_hits = 0, n;
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   fps_flash_sequencer #(.WRITE_CYCLES(WR_N), .ERASE_CYCLES(ER_N)) dut_u (
      .REF_CLK(clk), .RST_N(rst_n), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .XMOVE_WR(xwr), .XMOVE_SHORT(xshort), .XMOVE_ADDR(xaddr),
      .XMOVE_DATA(xdata), .XRAM_WR(xram_wr), .XRAM_ADDR(xram_addr), .XRAM_DATA(xram_data),
      .DBG_REQ(dbg_req), .DBG_ERASE(dbg_erase), .DBG_ADDR(dbg_addr), .DBG_DATA(dbg_data),
      .DBG_DONE(dbg_done), .CODE_ADDR(code_addr), .CODE_DATA(code_data), .CPU_STALL(stall));
   fps_core_model core_u (.clk(clk), .stall(stall), .move_wr(xwr), .move_short(xshort),
      .move_addr(xaddr), .move_data(xdata));
   // Record stores that were passed to data RAM
   always @(posedge clk) begin
      cycles++;
      if (xram_wr === 1'h1) begin
         ram_a = xram_addr;
         ram_d = xram_data;
         ram_hits++;
      end
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, s);
      end
   endtask
   // Hold the request until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      // No local limit: only the bench timeout may end a hung wait
      while (pready !== 1'h1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e, input string w);
      apb(1'h0, a, 32'h0);
      check(w, rd, e);
   endtask
   task automatic keys();
      wreg(8'h04, 32'ha5);
      wreg(8'h04, 32'hf1);
   endtask
   task automatic store(input logic s, input logic [15:0] a, input logic [7:0] d,
                        input int e, input string w);
      core_u.store(s, a, d, n);
      check(w, n, e);
   endtask
   task automatic peek(input logic [15:0] a, input logic [7:0] e, input string w);
      @(posedge clk);
      code_addr <= a;
      repeat (2) @(posedge clk);
      check(w, {24'h0, code_data}, {24'h0, e});
   endtask
   task automatic reset();
      rst_n <= 1'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'h0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {dbg_req, dbg_erase, dbg_addr, dbg_data, code_addr} = '0;
      reset();
      rreg(8'h00, 32'h0, "ctrl rst");
      rreg(8'h04, 32'h0, "key rst");
      rreg(8'h10, 32'h0, "stat rst");
      apb(1'h0, 8'h14, 32'h0);
      check("unmapped", {31'h0, er}, 32'h1);
      $display("test regs done");
      // Erase a page from a store anywhere inside it
      wreg(8'h08, 32'h1);
      wreg(8'h00, 32'h3);
      keys();
      rreg(8'h04, 32'h2, "key open");
      store(1'h0, 16'h02a7, 8'h00, ER_N, "erase len");
      peek(16'h0200, 8'hff, "pg lo");
      peek(16'h03ff, 8'hff, "pg hi");
      rreg(8'h04, 32'h0, "relock");
      $display("test erase done");
      // Program, then reprogram: bits can only clear
      wreg(8'h00, 32'h1);
      keys();
      store(1'h0, 16'h0201, 8'h5a, WR_N, "prog len");
      peek(16'h0201, 8'h5a, "prog");
      peek(16'h0202, 8'hff, "next");
      keys();
      store(1'h0, 16'h0201, 8'hf0, WR_N, "reprog len");
      peek(16'h0201, 8'h50, "and");
      keys();
      store(1'h1, 16'h0305, 8'h00, WR_N, "short len");
      peek(16'h0305, 8'hff, "short hi");
      peek(16'h0005, 8'h00, "short lo");
      $display("test program done");
      // Block mode: lone byte is held back, a pair commits in one write time
      wreg(8'h0c, 32'h1);
      keys();
      store(1'h0, 16'h0210, 8'h11, 0, "cache len");
      rreg(8'h10, 32'h4, "cached");
      peek(16'h0210, 8'hff, "held");
      keys();
      store(1'h0, 16'h0211, 8'h22, WR_N, "pair len");
      peek(16'h0210, 8'h11, "pair a");
      peek(16'h0211, 8'h22, "pair b");
      keys();
      store(1'h0, 16'h0220, 8'h33, 0, "lone len");
      wreg(8'h0c, 32'h0);
      peek(16'h0220, 8'hff, "lone");
      rreg(8'h00, 32'h1, "we sticky");
      wreg(8'h00, 32'h0);
      store(1'h0, 16'h1234, 8'h77, 0, "ram len");
      // The ram store is registered; let the recorder see it first
      repeat (2) @(posedge clk);
      check("ram", {ram_hits[7:0], ram_a, ram_d}, 32'h01123477);
      $display("test block done");
      // Debug port programs without keys
      @(posedge clk);
      dbg_req <= 1'h1;
      dbg_addr <= 16'h0230;
      dbg_data <= 8'h0f;
      n = 0;
      @(posedge clk);
      while (dbg_done !== 1'h1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      dbg_req <= 1'h0;
      check("dbg len", n, WR_N + 1);
      peek(16'h0230, 8'h0f, "dbg");
      $display("test debug done");
      // Key faults block flash moves and further keys until reset
      wreg(8'h04, 32'ha5);
      rreg(8'h04, 32'h1, "half");
      wreg(8'h04, 32'h00);
      rreg(8'h04, 32'h3, "bad key");
      rreg(8'h10, 32'h2, "dis flag");
      wreg(8'h00, 32'h1);
      store(1'h0, 16'h0240, 8'h00, 0, "dead len");
      peek(16'h0240, 8'hff, "dead");
      keys();
      rreg(8'h04, 32'h3, "stays");
      reset();
      rreg(8'h04, 32'h0, "revive");
      wreg(8'h04, 32'hf1);
      rreg(8'h04, 32'h3, "order");
      reset();
      wreg(8'h00, 32'h1);
      wreg(8'h08, 32'h1);
      store(1'h0, 16'h0250, 8'h00, 0, "nokey len");
      rreg(8'h04, 32'h3, "nokey");
      peek(16'h0250, 8'hff, "nokey pg");
      $display("test faults done");
      complete_run();
   end
endmodule
